// ### shared/vpqm_defs.svh
// Register offsets, field positions and reset values of the priority mapper
`ifndef VPQM_DEFS_SVH
`define VPQM_DEFS_SVH

// Register indices; byte address is four times the index
`define VPQM_ADDR_W 12
`define VPQM_IDX_W 10
`define VPQM_IDX_MAP_LOW 10'h080
`define VPQM_IDX_MAP_HIGH 10'h081
`define VPQM_IDX_SPLIT 10'h082
`define VPQM_IDX_CFG 10'h083
`define VPQM_IDX_STATUS 10'h084

// Reset values
`define VPQM_RST_MAP_LOW 8'h50
`define VPQM_RST_MAP_HIGH 8'hfa
`define VPQM_RST_SPLIT 2'h0
`define VPQM_RST_CFG 1'h0

// Field positions
`define VPQM_FLD_W 2
`define VPQM_TAG0_LSB 0
`define VPQM_TAG3_LSB 6
`define VPQM_TAG7_LSB 6
`define VPQM_SPLIT_LSB 0
`define VPQM_CFG_TWOQ_BIT 0
`define VPQM_ST_PRIO_LSB 0
`define VPQM_ST_QHIGH_BIT 2
`define VPQM_ST_SEEN_BIT 3

// AXI responses
`define VPQM_RESP_OKAY 2'h0
`define VPQM_RESP_SLVERR 2'h2

`endif

// ### shared/vpqm_pkg.sv
// Types shared by the priority mapper modules
package vpqm_pkg;
  typedef logic [1:0] vpqm_prio_t;
  typedef logic [2:0] vpqm_tag_t;
  typedef enum logic [1:0] {
    VPQM_SPLIT_TOP_ONLY = 2'b00,
    VPQM_SPLIT_MID_A = 2'b01,
    VPQM_SPLIT_MID_B = 2'b10,
    VPQM_SPLIT_ALL_BUT_ZERO = 2'b11
  } vpqm_split_t;
endpackage

// ### hw/vpqm_split.sv
// Folds a two-bit priority into the low or high queue of two
`timescale 1ns/100ps
module vpqm_split (
  input wire vpqm_pkg::vpqm_prio_t prio,
  input wire vpqm_pkg::vpqm_split_t sel,
  output wire to_high
);
  import vpqm_pkg::*;

  // Ends of the range are fixed; only middle results follow the split
  wire is_zero = (prio == 2'h0);
  wire is_top = (prio == 2'h3);
  wire all_high = (sel == VPQM_SPLIT_ALL_BUT_ZERO);
  wire top_only = (sel == VPQM_SPLIT_TOP_ONLY);
  // Middle encodings split at two: 0,1 low and 2,3 high
  wire mid_high = prio[1];

  assign to_high = is_zero ? 1'b0 :
                   is_top ? 1'b1 :
                   all_high ? 1'b1 :
                   top_only ? 1'b0 :
                   mid_high;
endmodule

// ### hw/vpqm_top.sv
// Tag priority mapper with two-queue split and AXI4-Lite registers
`timescale 1ns/100ps
`include "vpqm_defs.svh"
module vpqm_top (
  input wire clk,
  input wire nrst,
  input wire awvalid,
  output wire awready,
  input wire [`VPQM_ADDR_W-1:0] awaddr,
  input wire [2:0] awprot,
  input wire wvalid,
  output wire wready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  output wire bvalid,
  input wire bready,
  output wire [1:0] bresp,
  input wire arvalid,
  output wire arready,
  input wire [`VPQM_ADDR_W-1:0] araddr,
  input wire [2:0] arprot,
  output wire rvalid,
  input wire rready,
  output wire [31:0] rdata,
  output wire [1:0] rresp,
  input wire cls_valid,
  input wire vpqm_pkg::vpqm_tag_t cls_tag,
  input wire cls_use_tos,
  input wire vpqm_pkg::vpqm_prio_t cls_tos_priority,
  output wire q_valid,
  output wire vpqm_pkg::vpqm_prio_t q_priority,
  output wire q_high,
  output wire q_two_queue
);
  import vpqm_pkg::*;

  logic [7:0] map_low_q;
  logic [7:0] map_high_q;
  vpqm_split_t split_q;
  logic twoq_q;
  logic aw_held_q;
  logic w_held_q;
  logic [`VPQM_IDX_W-1:0] wr_idx_q;
  logic [7:0] wr_byte_q;
  logic wr_lane_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic q_valid_q;
  vpqm_prio_t q_priority_q;
  logic q_high_q;
  logic q_two_queue_q;
  logic seen_q;
  logic wr_low_seen_q;
  logic wr_high_seen_q;

  // Write channels are taken independently and paired afterwards
  wire aw_hs = awvalid && awready;
  wire w_hs = wvalid && wready;
  assign awready = !aw_held_q && !bvalid_q;
  assign wready = !w_held_q && !bvalid_q;
  wire do_write = aw_held_q && w_held_q && !bvalid_q;
  wire wr_en = do_write && wr_lane_q;
  wire wr_low = wr_en && (wr_idx_q == `VPQM_IDX_MAP_LOW);
  wire wr_high = wr_en && (wr_idx_q == `VPQM_IDX_MAP_HIGH);
  wire wr_split = wr_en && (wr_idx_q == `VPQM_IDX_SPLIT);
  wire wr_cfg = wr_en && (wr_idx_q == `VPQM_IDX_CFG);
  // Status is read-only, so a write there is refused
  wire wr_hit = (wr_idx_q == `VPQM_IDX_MAP_LOW) ||
                (wr_idx_q == `VPQM_IDX_MAP_HIGH) ||
                (wr_idx_q == `VPQM_IDX_SPLIT) ||
                (wr_idx_q == `VPQM_IDX_CFG);

  // Read decode
  wire ar_hs = arvalid && arready;
  assign arready = !rvalid_q;
  wire [`VPQM_IDX_W-1:0] rd_idx = araddr[`VPQM_ADDR_W-1:2];
  wire [7:0] rd_status = {4'h0, seen_q, q_high_q, q_priority_q};
  wire rd_lo = (rd_idx == `VPQM_IDX_MAP_LOW);
  wire rd_hi = (rd_idx == `VPQM_IDX_MAP_HIGH);
  wire rd_sp = (rd_idx == `VPQM_IDX_SPLIT);
  wire rd_cf = (rd_idx == `VPQM_IDX_CFG);
  wire rd_st = (rd_idx == `VPQM_IDX_STATUS);
  wire rd_hit = rd_lo || rd_hi || rd_sp || rd_cf || rd_st;
  wire [7:0] rd_byte = rd_lo ? map_low_q :
                       rd_hi ? map_high_q :
                       rd_sp ? {6'h00, split_q} :
                       rd_cf ? {7'h00, twoq_q} :
                       rd_st ? rd_status : 8'h00;

  // Write address and data holding
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      wr_idx_q <= '0;
      wr_byte_q <= 8'h00;
      wr_lane_q <= 1'b0;
    end else begin
      if (aw_hs) begin
        aw_held_q <= 1'b1;
        wr_idx_q <= awaddr[`VPQM_ADDR_W-1:2];
      end else if (do_write) begin
        aw_held_q <= 1'b0;
      end
      if (w_hs) begin
        w_held_q <= 1'b1;
        wr_byte_q <= wdata[7:0];
        wr_lane_q <= wstrb[0];
      end else if (do_write) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // Write response; unmapped or read-only targets answer SLVERR
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bvalid_q <= 1'b0;
      bresp_q <= `VPQM_RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? `VPQM_RESP_OKAY : `VPQM_RESP_SLVERR;
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Map and control registers; lane 0 strobe gates the update
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      map_low_q <= `VPQM_RST_MAP_LOW;
      map_high_q <= `VPQM_RST_MAP_HIGH;
      split_q <= vpqm_split_t'(`VPQM_RST_SPLIT);
      twoq_q <= `VPQM_RST_CFG;
    end else begin
      if (wr_low) map_low_q <= wr_byte_q;
      if (wr_high) map_high_q <= wr_byte_q;
      if (wr_split) split_q <= vpqm_split_t'(wr_byte_q[1:0]);
      if (wr_cfg) twoq_q <= wr_byte_q[`VPQM_CFG_TWOQ_BIT];
    end
  end

  // Read data registered, one cycle after the address is taken
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `VPQM_RESP_OKAY;
    end else if (ar_hs) begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h00_0000, rd_byte};
      rresp_q <= rd_hit ? `VPQM_RESP_OKAY : `VPQM_RESP_SLVERR;
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  // One field per tag value, low register first
  wire [15:0] map_all = {map_high_q, map_low_q};
  wire vpqm_prio_t tag_field [8];
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_tag
      assign tag_field[g] = map_all[g*`VPQM_FLD_W +: `VPQM_FLD_W];
    end
  endgenerate
  wire vpqm_prio_t tag_prio = tag_field[cls_tag];
  wire vpqm_prio_t cls_prio = cls_use_tos ? cls_tos_priority : tag_prio;
  wire cls_high;

  vpqm_split u_split (
    .prio(cls_prio),
    .sel(split_q),
    .to_high(cls_high)
  );

  // Classification result registered; queue bit only in two-queue mode
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q_valid_q <= 1'b0;
      q_priority_q <= 2'h0;
      q_high_q <= 1'b0;
      q_two_queue_q <= 1'b0;
      seen_q <= 1'b0;
    end else begin
      q_valid_q <= cls_valid;
      if (cls_valid) begin
        q_priority_q <= cls_prio;
        q_high_q <= twoq_q && cls_high;
        q_two_queue_q <= twoq_q;
        seen_q <= 1'b1;
      end
    end
  end

  assign q_valid = q_valid_q;
  assign q_priority = q_priority_q;
  assign q_high = q_high_q;
  assign q_two_queue = q_two_queue_q;

  // Helpers: has a register been written since reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_low_seen_q <= 1'b0;
      wr_high_seen_q <= 1'b0;
    end else begin
      if (wr_low) wr_low_seen_q <= 1'b1;
      if (wr_high) wr_high_seen_q <= 1'b1;
    end
  end

  sequence s_twoq_frame;
    cls_valid && twoq_q;
  endsequence
  sequence s_low_write;
    wr_low;
  endsequence

  AST_TAG_MAP: assert property (@(posedge clk) disable iff (!nrst)
    cls_valid && !cls_use_tos |=> q_valid && q_priority == $past(tag_prio))
    else $error("tag map field not applied");
  AST_TAG0_RESET: assert property (@(posedge clk) disable iff (!nrst)
    !wr_low_seen_q |-> map_low_q[`VPQM_TAG0_LSB +: 2] == 2'h0)
    else $error("tag zero field reset wrong");
  AST_TAG7_RESET: assert property (@(posedge clk) disable iff (!nrst)
    !wr_high_seen_q |-> map_high_q[`VPQM_TAG7_LSB +: 2] == 2'h3)
    else $error("tag seven field reset wrong");
  AST_TAG3_RESET: assert property (@(posedge clk) disable iff (!nrst)
    !wr_low_seen_q |-> map_low_q[`VPQM_TAG3_LSB +: 2] == 2'h1)
    else $error("tag three field reset wrong");
  AST_TOS_USED: assert property (@(posedge clk) disable iff (!nrst)
    cls_valid && cls_use_tos |=> q_priority == $past(cls_tos_priority))
    else $error("tos priority not used");
  AST_FOURQ_LOW: assert property (@(posedge clk) disable iff (!nrst)
    cls_valid && !twoq_q |=> !q_high && !q_two_queue)
    else $error("queue bit set outside two-queue mode");
  AST_ENDS_FIXED: assert property (@(posedge clk) disable iff (!nrst)
    s_twoq_frame ##0 (cls_prio == 2'h0 || cls_prio == 2'h3)
    |=> q_valid && q_high == (q_priority == 2'h3))
    else $error("end result in wrong queue");
  AST_SPLIT_DEFAULT: assert property (@(posedge clk) disable iff (!nrst)
    s_twoq_frame ##0 (split_q == VPQM_SPLIT_TOP_ONLY)
    |=> q_high == (q_priority == 2'h3))
    else $error("default split wrong");
  AST_SPLIT_MID: assert property (@(posedge clk) disable iff (!nrst)
    s_twoq_frame ##0 (split_q == VPQM_SPLIT_MID_A ||
    split_q == VPQM_SPLIT_MID_B) |=> q_high == q_priority[1])
    else $error("middle split wrong");
  AST_SPLIT_ALL: assert property (@(posedge clk) disable iff (!nrst)
    s_twoq_frame ##0 (split_q == VPQM_SPLIT_ALL_BUT_ZERO)
    |=> q_high == (q_priority != 2'h0))
    else $error("split 11 wrong");
  AST_WRITE_VISIBLE: assert property (@(posedge clk) disable iff (!nrst)
    s_low_write |=> map_low_q == $past(wr_byte_q) && bvalid)
    else $error("map write not applied");
  AST_READ_SPLIT: assert property (@(posedge clk) disable iff (!nrst)
    ar_hs && rd_sp |=> rvalid && rdata[1:0] == $past(split_q))
    else $error("split readback wrong");
endmodule

// ### bench/vpqm_cls_model.sv
// Classifier stand-in that offers one frame per call, no backpressure
`timescale 1ns/100ps
module vpqm_cls_model (
  output logic cls_valid,
  output vpqm_pkg::vpqm_tag_t cls_tag,
  output logic cls_use_tos,
  output vpqm_pkg::vpqm_prio_t cls_tos_priority
);
  import vpqm_pkg::*;
  initial begin
    cls_valid = 1'b0;
    cls_tag = 3'h0;
    cls_use_tos = 1'b0;
    cls_tos_priority = 2'h0;
  end
  // Called right after a rising edge; idle lines flip so stale data is seen
  task automatic send(input logic v, input vpqm_tag_t t, input logic u,
                      input vpqm_prio_t p);
    cls_valid <= v;
    cls_tag <= v ? t : ~cls_tag;
    cls_use_tos <= v ? u : ~cls_use_tos;
    cls_tos_priority <= v ? p : ~cls_tos_priority;
  endtask
endmodule

// ### bench/tb_vpqm_top.sv
// Self-checking bench for the tag priority mapper
`timescale 1ns/100ps
`include "vpqm_defs.svh"
module tb_vpqm_top;
  import vpqm_pkg::*;
  localparam logic [11:0] A_ML = {`VPQM_IDX_MAP_LOW, 2'b00};
  localparam logic [11:0] A_MH = {`VPQM_IDX_MAP_HIGH, 2'b00};
  localparam logic [11:0] A_SP = {`VPQM_IDX_SPLIT, 2'b00};
  localparam logic [11:0] A_CF = {`VPQM_IDX_CFG, 2'b00};
  localparam logic [11:0] A_ST = {`VPQM_IDX_STATUS, 2'b00};
  localparam logic [1:0] OK = `VPQM_RESP_OKAY;
  localparam logic [1:0] SE = `VPQM_RESP_SLVERR;
  logic clk = 1'b0, nrst = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic [3:0] ws = 4'hf;
  wire awready, wready, bvalid, arready, rvalid;
  wire q_valid, q_high, q_two_queue, cls_valid, cls_use_tos;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire vpqm_tag_t cls_tag;
  wire vpqm_prio_t cls_tos_priority, q_priority;
  int err_count = 0, checked = 0, cycles = 0;
  // Shadow of the register contents, starting at reset values
  logic [7:0] ml = 8'h50, mh = 8'hfa;
  logic [1:0] sp = 2'h0;
  logic cf = 1'b0;
  vpqm_top dut (.clk, .nrst, .awvalid, .awready, .awaddr, .awprot(3'h0),
    .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
    .arready, .araddr, .arprot(3'h0), .rvalid, .rready, .rdata, .rresp,
    .cls_valid, .cls_tag, .cls_use_tos, .cls_tos_priority, .q_valid,
    .q_priority, .q_high, .q_two_queue);
  vpqm_cls_model u_cls (.cls_valid, .cls_tag, .cls_use_tos,
    .cls_tos_priority);
  initial forever #2 clk = ~clk;
  // Hang guard, far above the five hundred or so cycles the run needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    if (err_count == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk_data(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("FAIL %0t data got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("FAIL %0t resp got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_frame(input logic [4:0] g, input logic [4:0] e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("FAIL %0t frame got %h exp %h", $time, g, e);
    end
  endtask
  // Address and data offered together, each dropped once taken
  task automatic axw(input logic [11:0] a, input logic [7:0] d,
                     input logic [1:0] er);
    @(posedge clk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    wstrb <= ws;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk_resp(bresp, er);
  endtask
  task automatic axr(input logic [11:0] a, input logic [7:0] ed,
                     input logic [1:0] er);
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    rready <= 1'b0;
    chk_data(rdata, {24'h00_0000, ed});
    chk_resp(rresp, er);
  endtask
  // Expected {two_queue, high, priority} from the shadow registers
  function automatic logic [3:0] exp_frame(input logic [2:0] t,
      input logic u, input logic [1:0] p);
    logic [15:0] m;
    logic [1:0] pr;
    logic h;
    m = {mh, ml};
    pr = u ? p : m[t*2 +: 2];
    h = cf && (sp == 2'b00 ? pr == 2'b11 : sp == 2'b11 ? pr != 2'b00 : pr[1]);
    return {cf, h, pr};
  endfunction
  initial begin
    logic [2:0] t;
    logic u;
    logic [1:0] p;
    logic [3:0] cur, prev;
    void'($urandom(32'h4d2c_c056));
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    axr(12'h3fc, 8'h00, SE);
    axw(A_ST, 8'h0f, SE);
    // Lane 0 strobe off: answered, but the split must not change
    ws = 4'h0;
    axw(A_SP, 8'h03, OK);
    ws = 4'hf;
    axr(A_SP, 8'h00, OK);
    // Round 0 reset map, round 1 two-queue default split, then random
    for (int r = 0; r < 12; r++) begin
      if (r > 0) cf = 1'b1;
      if (r > 1) begin
        ml = 8'($urandom);
        mh = 8'($urandom);
        sp = r[1:0];
        cf = (r % 5 != 3);
      end
      if (r > 0) begin
        axw(A_ML, ml, OK);
        axw(A_MH, mh, OK);
        axw(A_SP, {6'h00, sp}, OK);
        axw(A_CF, {7'h00, cf}, OK);
      end
      axr(A_ML, ml, OK);
      axr(A_MH, mh, OK);
      axr(A_SP, {6'h00, sp}, OK);
      axr(A_CF, {7'h00, cf}, OK);
      // Frames back to back, each checked the cycle after it is taken
      for (int i = 0; i <= 8; i++) begin
        @(posedge clk);
        t = (r < 2) ? i[2:0] : 3'($urandom);
        u = (r < 2) ? 1'b0 : 1'($urandom);
        p = 2'($urandom);
        u_cls.send(i < 8, t, u, p);
        cur = exp_frame(t, u, p);
        #1;
        if (i > 0)
          chk_frame({q_valid, q_two_queue, q_high, q_priority},
                    {1'b1, prev});
        // Idle slot at the end leaves the last real frame in prev
        if (i < 8) prev = cur;
      end
      axr(A_ST, {4'h0, 1'b1, prev[2:0]}, OK);
    end
    end_of_test();
  end
endmodule
